// file: psync_pkg.sv
// shared constants for the programmable synchronous memory interface
package psync_pkg;
    // secondary control word layout, one word per chip-enable space
    localparam int  CFG_W        = 7;
    localparam int  RL_LSB       = 0;     // read latency, 2 bits
    localparam int  WL_LSB       = 2;     // write latency, 2 bits
    localparam int  LAT_W        = 2;
    localparam int  SEL_EXT_BIT  = 4;     // select extend
    localparam int  RD_MODE_BIT  = 5;     // read enable mode
    localparam int  CLKSEL_BIT   = 6;     // 0: clock out one, 1: clock out two
    localparam logic [CFG_W-1:0] CFG_RESET = 7'h00;
    localparam int  NUM_LINK_CLK = 2;
    typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_DESEL} seq_state_t;
endpackage

// file: link_tick_if.sv
// carries the output-clock selection and its edge tick between modules
`timescale 1ns/1ps
interface link_tick_if;
    logic sel;   // selected output clock
    logic tick;  // one-cycle pulse per rising edge of the selected clock
    modport seq (output sel, input tick);
    modport trk (input sel, output tick);
endinterface

// file: link_clock_tracker.sv
// synchronises both external output clocks and flags rising edges of the chosen one
`timescale 1ns/1ps
module link_clock_tracker
    import psync_pkg::*;
(
    input  wire logic                    core_clk,    // core clock
    input  wire logic                    sys_rst,     // synchronous reset
    input  wire logic [NUM_LINK_CLK-1:0] link_clk,    // both output clocks
    link_tick_if.trk                     tk           // selection and tick
);
    logic [NUM_LINK_CLK-1:0] s1_q, s2_q, s1_d, s2_d;
    logic                    prev_q, prev_d, tick_q, tick_d;

    // two-flop synchroniser per clock; first stage feeds only the second
    for (genvar i = 0; i < NUM_LINK_CLK; i++) begin : g_sync
        always_comb begin
            s1_d[i] = link_clk[i];
            s2_d[i] = s1_q[i];
        end
    end

    // edge detect on the selected, synchronised clock
    always_comb begin
        prev_d = s2_q[tk.sel];
        tick_d = s2_q[tk.sel] & ~prev_q;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s1_q   <= '0;
            s2_q   <= '0;
            prev_q <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            s1_q   <= s1_d;
            s2_q   <= s2_d;
            prev_q <= prev_d;
            tick_q <= tick_d;
        end
    end

    assign tk.tick = tick_q;
endmodule

// file: prog_sync_memory_interface.sv
// sequencer for synchronous burst sram and synchronous fifo accesses
`timescale 1ns/1ps
module prog_sync_memory_interface
    import psync_pkg::*;
#(
    parameter int NUM_SPACES = 4,
    parameter int ADDR_W     = 20,
    parameter int DATA_W     = 32,
    parameter int SPACE_W    = 2
) (
    input  wire logic                    core_clk,               // core clock
    input  wire logic                    sys_rst,                // synchronous reset
    input  wire logic [NUM_LINK_CLK-1:0] ext_clock_out,          // [0] one, [1] two
    input  wire logic                    cfg_wr,                 // write secondary control
    input  wire logic [SPACE_W-1:0]      cfg_space,              // space written
    input  wire logic [CFG_W-1:0]        cfg_data,               // secondary control word
    input  wire logic                    req_valid,              // access request
    output logic                         req_ready,              // request may be taken
    input  wire logic                    req_write,              // 1 write, 0 read
    input  wire logic [SPACE_W-1:0]      req_space,              // chip-enable space
    input  wire logic [ADDR_W-1:0]       req_addr,               // word address
    input  wire logic [DATA_W-1:0]       req_wdata,              // write data
    input  wire logic [DATA_W/8-1:0]     req_be,                 // byte enables, high true
    output logic                         rd_valid,               // read data pulse
    output logic [DATA_W-1:0]            rd_data,                // read data
    output logic                         busy,                   // access in progress
    input  wire logic [2:0]              alt_strobe_n,           // async/dram strobe values
    output logic [NUM_SPACES-1:0]        space_chip_select_n,    // chip selects
    output logic                         sync_address_strobe_n,  // also fifo_read_enable
    output logic                         sync_output_enable_n,   // output enable strobe
    output logic                         sync_write_enable_n,    // write enable strobe
    output logic [ADDR_W-1:0]            mem_addr,               // address pins
    output logic [DATA_W/8-1:0]          mem_be_n,               // byte enable pins
    input  wire logic [DATA_W-1:0]       mem_data_in,            // data pins in
    output logic [DATA_W-1:0]            mem_data_out,           // data pins out
    output logic                         mem_data_oe_n           // low while driving data
);
    import psync_pkg::*;

    link_tick_if tk ();
    link_clock_tracker u_trk (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .link_clk (ext_clock_out),
        .tk       (tk)
    );

    logic [CFG_W-1:0]      sec_q [NUM_SPACES];
    logic [CFG_W-1:0]      sec_d [NUM_SPACES];
    seq_state_t            st_q, st_d;
    logic [LAT_W-1:0]      ph_q, ph_d;
    logic [CFG_W-1:0]      act_q, act_d;
    logic                  act_wr_q, act_wr_d;
    logic [SPACE_W-1:0]    act_sp_q, act_sp_d;
    logic                  pend_q, pend_d, pwr_q, pwr_d;
    logic [SPACE_W-1:0]    psp_q, psp_d;
    logic [ADDR_W-1:0]     padr_q, padr_d;
    logic [DATA_W-1:0]     pdat_q, pdat_d;
    logic [DATA_W/8-1:0]   pbe_q, pbe_d;
    logic [DATA_W-1:0]     din1_q, din2_q, rdat_q, rdat_d, dout_q, dout_d;
    logic                  rdv_q, rdv_d, rdy_q, rdy_d, busy_q, busy_d;
    logic [NUM_SPACES-1:0] cs_q, cs_d;
    logic                  ads_q, ads_d, oe_q, oe_d, we_q, we_d, doe_q, doe_d;
    logic [ADDR_W-1:0]     adr_q, adr_d;
    logic [DATA_W/8-1:0]   be_q, be_d;
    logic                  start, last, s_oe, s_act;

    // clock choice follows the space being worked on, or the one waiting
    assign tk.sel = pend_q && st_q == ST_IDLE ? sec_q[psp_q][CLKSEL_BIT]
                                              : act_q[CLKSEL_BIT];

    // per-space secondary control words
    always_comb begin
        sec_d = sec_q;
        if (cfg_wr) begin
            sec_d[cfg_space] = cfg_data;
        end
    end

    // sequencer: state only advances on an edge of the selected clock
    always_comb begin
        st_d     = st_q;
        ph_d     = ph_q;
        act_d    = act_q;
        act_wr_d = act_wr_q;
        act_sp_d = act_sp_q;
        pend_d   = pend_q;
        pwr_d    = pwr_q;
        psp_d    = psp_q;
        padr_d   = padr_q;
        pdat_d   = pdat_q;
        pbe_d    = pbe_q;
        rdat_d   = rdat_q;
        rdv_d    = 1'b0;
        adr_d    = adr_q;
        be_d     = be_q;
        dout_d   = dout_q;
        start    = 1'b0;
        last     = 1'b0;
        if (tk.tick) begin
            unique case (st_q)
                ST_IDLE: start = pend_q;
                ST_BUSY: begin
                    last = act_wr_q ? ph_q == act_q[WL_LSB +: LAT_W]
                                    : ph_q == act_q[RL_LSB +: LAT_W];
                    if (!act_wr_q && last) begin
                        rdat_d = din2_q;
                        rdv_d  = 1'b1;
                    end
                    if (!last) begin
                        ph_d = ph_q + 2'd1;
                    end else if (act_q[RD_MODE_BIT]) begin
                        st_d  = ST_IDLE;
                        start = pend_q;
                    end else begin
                        st_d = ST_DESEL;
                    end
                end
                ST_DESEL: begin
                    st_d  = ST_IDLE;
                    start = pend_q;
                end
            endcase
        end
        if (start) begin
            st_d     = ST_BUSY;
            ph_d     = '0;
            act_d    = sec_q[psp_q];
            act_wr_d = pwr_q;
            act_sp_d = psp_q;
            adr_d    = padr_q;
            be_d     = ~pbe_q;
            dout_d   = pdat_q;
            pend_d   = 1'b0;
        end
        // single waiting slot; it frees in the cycle its command starts
        if (req_valid && rdy_q) begin
            pend_d = 1'b1;
            pwr_d  = req_write;
            psp_d  = req_space;
            padr_d = req_addr;
            pdat_d = req_wdata;
            pbe_d  = req_be;
        end
        rdy_d  = ~pend_d;
        busy_d = st_d != ST_IDLE || pend_d;
    end

    // pin values are derived from the next state so each pin is a flop
    always_comb begin
        s_act = st_d != ST_IDLE;
        s_oe  = st_d == ST_BUSY && !act_wr_d;
        cs_d  = '1;
        if (st_d == ST_BUSY && (ph_d == '0 || (act_d[SEL_EXT_BIT] && s_oe))) begin
            cs_d[act_sp_d] = 1'b0;
        end
        // outside synchronous accesses the shared pins keep their other roles
        ads_d = s_act ? !(st_d == ST_BUSY && ph_d == '0) : alt_strobe_n[0];
        oe_d  = s_act ? !s_oe : alt_strobe_n[1];
        we_d  = s_act ? !(st_d == ST_BUSY && act_wr_d && ph_d == '0)
                      : alt_strobe_n[2];
        doe_d = !(st_d == ST_BUSY && act_wr_d
                  && ph_d == act_d[WL_LSB +: LAT_W]);
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_SPACES; i++) begin
                sec_q[i] <= CFG_RESET;
            end
            st_q   <= ST_IDLE;
            ph_q   <= '0;
            act_q  <= CFG_RESET;
            act_wr_q <= 1'b0;
            act_sp_q <= '0;
            pend_q <= 1'b0;
            pwr_q  <= 1'b0;
            psp_q  <= '0;
            padr_q <= '0;
            pdat_q <= '0;
            pbe_q  <= '0;
            din1_q <= '0;
            din2_q <= '0;
            rdat_q <= '0;
            rdv_q  <= 1'b0;
            rdy_q  <= 1'b0;
            busy_q <= 1'b0;
            cs_q   <= '1;
            ads_q  <= 1'b1;
            oe_q   <= 1'b1;
            we_q   <= 1'b1;
            doe_q  <= 1'b1;
            adr_q  <= '0;
            be_q   <= '1;
            dout_q <= '0;
        end else begin
            sec_q  <= sec_d;
            st_q   <= st_d;
            ph_q   <= ph_d;
            act_q  <= act_d;
            act_wr_q <= act_wr_d;
            act_sp_q <= act_sp_d;
            pend_q <= pend_d;
            pwr_q  <= pwr_d;
            psp_q  <= psp_d;
            padr_q <= padr_d;
            pdat_q <= pdat_d;
            pbe_q  <= pbe_d;
            din1_q <= mem_data_in;  // data pins cross in through two flops
            din2_q <= din1_q;
            rdat_q <= rdat_d;
            rdv_q  <= rdv_d;
            rdy_q  <= rdy_d;
            busy_q <= busy_d;
            cs_q   <= cs_d;
            ads_q  <= ads_d;
            oe_q   <= oe_d;
            we_q   <= we_d;
            doe_q  <= doe_d;
            adr_q  <= adr_d;
            be_q   <= be_d;
            dout_q <= dout_d;
        end
    end

    assign req_ready             = rdy_q;
    assign rd_valid              = rdv_q;
    assign rd_data               = rdat_q;
    assign busy                  = busy_q;
    assign space_chip_select_n   = cs_q;
    assign sync_address_strobe_n = ads_q;
    assign sync_output_enable_n  = oe_q;
    assign sync_write_enable_n   = we_q;
    assign mem_addr              = adr_q;
    assign mem_be_n              = be_q;
    assign mem_data_out          = dout_q;
    assign mem_data_oe_n         = doe_q;

    // checks on the sequencer
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    read_latency_a: assert property (rd_valid |-> $past(st_q) == ST_BUSY && !$past(act_wr_q)
        && $past(ph_q) == $past(act_q[RL_LSB +: LAT_W]))
        else $error("read data taken at wrong latency");
    write_latency_a: assert property (!mem_data_oe_n |-> act_wr_q
        && ph_q == act_q[WL_LSB +: LAT_W] && st_q == ST_BUSY)
        else $error("write data driven at wrong latency");
    select_drop_a: assert property (st_q == ST_BUSY && ph_q != '0 && !act_q[SEL_EXT_BIT]
        |-> &space_chip_select_n)
        else $error("chip select held past command");
    select_extend_a: assert property (!sync_output_enable_n && st_q == ST_BUSY
        && act_q[SEL_EXT_BIT] |-> !space_chip_select_n[act_sp_q])
        else $error("chip select not held with output enable");
    deselect_gap_a: assert property (st_q == ST_IDLE && $past(st_q) == ST_BUSY
        |-> $past(act_q[RD_MODE_BIT]))
        else $error("deselect cycle skipped");
    no_deselect_a: assert property (st_q == ST_DESEL
        |-> !act_q[RD_MODE_BIT] && &space_chip_select_n && sync_address_strobe_n)
        else $error("deselect cycle in fifo mode");
    clock_timed_a: assert property (st_q != $past(st_q) |-> $past(tk.tick))
        else $error("state moved off a clock edge");
    strobe_mux_a: assert property (st_q == ST_IDLE
        |-> sync_address_strobe_n == $past(alt_strobe_n[0])
            && sync_write_enable_n == $past(alt_strobe_n[2]))
        else $error("shared strobe not released");
    space_config_a: assert property (cfg_wr |=> sec_q[$past(cfg_space)] == $past(cfg_data))
        else $error("secondary control not stored");
    pin_edge_a: assert property ($fell(sync_address_strobe_n) && st_q == ST_BUSY
        |-> $past(tk.tick))
        else $error("command off a clock edge");

    read_seen_c: cover property (rd_valid && act_q[RL_LSB +: LAT_W] == 2'd3);
    write_seen_c: cover property (!mem_data_oe_n && act_q[WL_LSB +: LAT_W] == 2'd1);
    fifo_b2b_c: cover property (st_q == ST_BUSY && ph_q == '0 && $past(st_q) == ST_BUSY
        && $past(ph_q) != '0);
endmodule

// file: sync_sram_model.sv
// behavioural synchronous sram standing on the far side of the sequencer
`timescale 1ns/1ps
module sync_sram_model (
    input  wire logic        lclk,   // selected output clock
    input  wire logic [1:0]  rl,     // read latency of the space in use
    input  wire logic [1:0]  wl,     // write latency of the space in use
    input  wire logic [3:0]  cs_n,   // chip selects
    input  wire logic        ads_n,  // address strobe
    input  wire logic        we_n,   // write enable
    input  wire logic [19:0] addr,   // address pins
    input  wire logic [3:0]  be_n,   // byte enables
    input  wire logic [31:0] wdata,  // data from the device
    input  wire logic        doe_n,  // device drives data when low
    output logic      [31:0] rdata   // data to the device
);
    logic [31:0] mem [256];

    initial rdata = 32'h0;

    // one process per command, so latencies may overlap like a real pipeline
    task automatic serve(input logic wr, input logic [7:0] a, input logic [3:0] be,
                         input logic [1:0] r, input logic [1:0] w);
        repeat (wr ? w : r) @(posedge lclk);
        if (wr) begin
            for (int b = 0; b < 4; b++) begin
                if (!doe_n && !be[b]) mem[a][8*b +: 8] = wdata[8*b +: 8];
            end
        end else begin
            #1 rdata = mem[a];
            @(posedge lclk);
            #0.5 rdata = ~rdata; // hold has run out, so the bus no longer shows the word
        end
    endtask

    // a selected cycle with the strobe low is a command
    always @(posedge lclk) begin
        if (!(&cs_n) && !ads_n) begin
            fork
                serve(!we_n, addr[7:0], be_n, rl, wl);
            join_none
        end
    end
endmodule

// file: prog_sync_memory_interface_tb_top.sv
// self-checking bench for the synchronous memory sequencer
`timescale 1ns/1ps
module prog_sync_memory_interface_tb_top;
    import psync_pkg::*;
    typedef struct {logic [6:0] cfg; logic [1:0] sp; logic [31:0] d;} row_t;
    logic             core_clk, sys_rst, cfg_wr, req_valid, req_write, req_ready;
    logic             rd_valid, busy, ads_n, oe_n, we_n, doe_n, ads_q;
    logic [1:0]       link_clk, cfg_space, req_space, sel_sp;
    logic [CFG_W-1:0] cfg_data;
    logic [CFG_W-1:0] shadow [4];
    logic [19:0]      req_addr, mem_addr;
    logic [31:0]      req_wdata, rd_data, din, dout, rd_seen;
    logic [3:0]       cs_n, be_n;
    logic [2:0]       alt_n;
    int               n_fail, cmp_count, cyc, last_fall, gap, cs_lo, oe_lo, got, c0, o0, g0;
    row_t rows [6] = '{'{7'h00, 2'h0, 32'h1111_0001}, '{7'h05, 2'h1, 32'hA5A5_0002},
                       '{7'h1A, 2'h2, 32'h5A5A_0003}, '{7'h6F, 2'h3, 32'hDEAD_0004},
                       '{7'h53, 2'h1, 32'hBEEF_0005}, '{7'h27, 2'h2, 32'hC0DE_0006}};
    // write latency 1 so the strobe rises between fifo accesses and each command shows a fall
    int gaps [4][2] = '{'{'h04, 24}, '{'h24, 16}, '{'h64, 20}, '{'h44, 30}};

    prog_sync_memory_interface i_dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .ext_clock_out(link_clk),
        .cfg_wr(cfg_wr), .cfg_space(cfg_space), .cfg_data(cfg_data),
        .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
        .req_space(req_space), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_be(4'hF), .rd_valid(rd_valid), .rd_data(rd_data), .busy(busy),
        .alt_strobe_n(alt_n), .space_chip_select_n(cs_n), .sync_address_strobe_n(ads_n),
        .sync_output_enable_n(oe_n), .sync_write_enable_n(we_n), .mem_addr(mem_addr),
        .mem_be_n(be_n), .mem_data_in(din), .mem_data_out(dout), .mem_data_oe_n(doe_n));

    sync_sram_model i_mem (
        .lclk(link_clk[shadow[sel_sp][CLKSEL_BIT]]), .rl(shadow[sel_sp][1:0]),
        .wl(shadow[sel_sp][3:2]), .cs_n(cs_n), .ads_n(ads_n), .we_n(we_n),
        .addr(mem_addr), .be_n(be_n), .wdata(dout), .doe_n(doe_n), .rdata(din));

    // core clock and two free-running output clocks of unrelated phase
    initial begin
        core_clk = 0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        link_clk = 2'h0;
        #17;
        forever #160 link_clk[0] = ~link_clk[0];
    end
    initial begin
        #53;
        forever #200 link_clk[1] = ~link_clk[1];
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // pin monitor: read capture, strobe spacing, select versus output enable, time limit
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        ads_q <= ads_n;
        if (rd_valid === 1'b1) begin
            rd_seen <= rd_data;
            got <= got + 1;
        end
        if (ads_n === 1'b0 && ads_q === 1'b1) begin
            gap <= cyc - last_fall;
            last_fall <= cyc;
        end
        cs_lo <= cs_lo + int'((&cs_n) === 1'b0 && oe_n === 1'b0);
        oe_lo <= oe_lo + int'(oe_n === 1'b0);
        if (cyc == 20000) begin
            n_fail++;
            test_done();
        end
    end

    task automatic cfg(input logic [1:0] s, input logic [6:0] v);
        @(negedge core_clk);
        cfg_wr = 1;
        cfg_space = s;
        cfg_data = v;
        shadow[s] = v;
        @(negedge core_clk);
        cfg_wr = 0;
    endtask

    // request held until an edge samples ready high
    task automatic acc(input logic w, input logic [1:0] s, input logic [19:0] a,
                       input logic [31:0] d);
        @(negedge core_clk);
        req_valid = 1;
        req_write = w;
        req_space = s;
        req_addr = a;
        req_wdata = d;
        sel_sp = s;
        @(posedge core_clk);
        while (req_ready !== 1'b1) @(posedge core_clk);
        @(negedge core_clk);
        req_valid = 0;
    endtask

    task automatic idle();
        @(negedge core_clk);
        while (busy !== 1'b0) @(negedge core_clk);
    endtask

    initial begin
        {cfg_wr, req_valid, req_write, cfg_space, req_space, sel_sp} = '0;
        sys_rst = 1'b1;
        {cfg_data, req_addr, req_wdata, n_fail, cmp_count, cyc, last_fall, gap} = '0;
        {cs_lo, oe_lo, got, ads_q, alt_n} = '1;
        sel_sp = 2'h0;
        got = 0;
        foreach (shadow[i]) shadow[i] = CFG_RESET;
        repeat (6) @(negedge core_clk);
        check("cs_n in reset", cs_n, 4'hF);
        sys_rst = 0;
        @(negedge core_clk);
        check("ready after reset", req_ready, 1'b1);
        // per-space latencies, select extend, mode and clock choice, write then read back
        for (int i = 0; i < 6; i++) begin
            cfg(rows[i].sp, rows[i].cfg);
            acc(1, rows[i].sp, 20'(i), rows[i].d);
            idle();
            c0 = cs_lo;
            o0 = oe_lo;
            g0 = got;
            acc(0, rows[i].sp, 20'(i), 32'h0);
            while (got == g0) @(negedge core_clk);
            idle();
            check("read word", rd_seen, rows[i].d);
            if (rows[i].cfg[4]) check("cs with oe", 32'(cs_lo - c0), 32'(oe_lo - o0));
            else check("cs drops early", 32'(cs_lo - c0 < oe_lo - o0), 32'(rows[i].cfg[1:0] != 0));
        end
        // back-to-back writes: deselect phase only in address-strobe mode
        for (int j = 0; j < 4; j++) begin
            cfg(2'h3, 7'(gaps[j][0]));
            acc(1, 2'h3, 20'h40, 32'h0000_0040);
            acc(1, 2'h3, 20'h41, 32'h0000_0041);
            idle();
            check("command spacing", 32'(gap), 32'(gaps[j][1]));
        end
        alt_n = 3'h2;
        repeat (2) @(negedge core_clk);
        check("idle shared pins", {29'h0, we_n, oe_n, ads_n}, 32'h2);
        test_done();
    end
endmodule
